/* File: common/t2cr_pkg.sv */
// Constants for the reloadable 16-bit timer two block
package t2cr_pkg;
    // Machine cycle is twelve oscillator periods; phase 0 is S1P1
    localparam int T2CR_OSC_PER_CYCLE = 12;
    localparam logic [3:0] T2CR_PH_S1P1 = 4'h0;
    localparam logic [3:0] T2CR_PH_S2P1 = 4'h2;
    localparam logic [3:0] T2CR_PH_S5P2 = 4'h9;
    localparam logic [3:0] T2CR_PH_LAST = 4'(T2CR_OSC_PER_CYCLE - 1);
    // Register addresses on the special function register bus
    localparam logic [7:0] T2CR_ADDR_CTRL = 8'hc8;
    localparam logic [7:0] T2CR_ADDR_RLD_LO = 8'hc2;
    localparam logic [7:0] T2CR_ADDR_RLD_HI = 8'hc3;
    localparam logic [7:0] T2CR_ADDR_CNT_LO = 8'hc4;
    localparam logic [7:0] T2CR_ADDR_CNT_HI = 8'hc5;
    localparam logic [7:0] T2CR_ADDR_IRQ = 8'hc6;
    localparam logic [7:0] T2CR_ADDR_EN = 8'hc7;
    // Control field positions
    localparam int T2CR_CTRL_SEL = 0;
    localparam int T2CR_CTRL_CM = 2;
    localparam int T2CR_CTRL_RLD = 3;
    localparam int T2CR_CTRL_EXT2_POL = 5;
    localparam int T2CR_CTRL_CH0_POL = 6;
    localparam int T2CR_CTRL_PS = 7;
    // Interrupt request and enable field positions
    localparam int T2CR_IRQ_CH0 = 2;
    localparam int T2CR_IRQ_OVF = 6;
    localparam int T2CR_IRQ_EXF = 7;
    localparam int T2CR_EN_EXEN = 3;
    // Reset values and the all-ones counter maximum
    localparam logic [7:0] T2CR_CTRL_RST = 8'h00;
    localparam logic [15:0] T2CR_CNT_RST = 16'h0000;
    localparam logic [15:0] T2CR_RLD_RST = 16'h0000;
    localparam logic [15:0] T2CR_CNT_MAX = 16'hffff;
    // Input select and reload mode encodings
    localparam logic [1:0] T2CR_SEL_STOP = 2'h0;
    localparam logic [1:0] T2CR_SEL_TIMER = 2'h1;
    localparam logic [1:0] T2CR_SEL_EVENT = 2'h2;
    localparam logic [1:0] T2CR_SEL_GATED = 2'h3;
    localparam logic [1:0] T2CR_RLD_OVF = 2'h2;
    localparam logic [1:0] T2CR_RLD_TRIG = 2'h3;
    // Pin channels of the edge detectors
    localparam int T2CR_PIN_CNT = 0;
    localparam int T2CR_PIN_TRIG = 1;
    localparam int T2CR_PIN_CH0 = 2;
    localparam int T2CR_NUM_PINS = 3;
endpackage : t2cr_pkg

/* File: common/t2cr_pin_if.sv */
// Sample strobe and detected levels and edges of one input pin
`timescale 1ns/1ps
interface t2cr_pin_if;
    logic sample_en;
    logic level;
    logic fall;
    logic rise;
    modport edge_end (input sample_en, output level, output fall, output rise);
    modport core_end (output sample_en, input level, input fall, input rise);
endinterface : t2cr_pin_if

/* File: core/t2cr_edge.sv */
// Pin synchroniser with once-per-machine-cycle edge sampler
`timescale 1ns/1ps
module t2cr_edge
    import t2cr_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input wire logic pin,
    t2cr_pin_if.edge_end pif
);
    typedef struct packed {
        logic sync1;
        logic sync2;
        logic prev;
        logic fall;
        logic rise;
    } t2cr_edge_s;

    t2cr_edge_s st_r;
    t2cr_edge_s st_nxt;

    always_comb begin
        st_nxt = st_r;
        st_nxt.sync1 = pin;
        st_nxt.sync2 = st_r.sync1;
        // Edge result holds for one full machine cycle
        if (pif.sample_en) begin
            st_nxt.prev = st_r.sync2;
            st_nxt.fall = st_r.prev && !st_r.sync2; // RULE_04
            st_nxt.rise = !st_r.prev && st_r.sync2;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            st_r <= '{sync1: 1'b1, sync2: 1'b1, prev: 1'b1,
                      fall: 1'b0, rise: 1'b0};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign pif.level = st_r.sync2;
    assign pif.fall = st_r.fall;
    assign pif.rise = st_r.rise;
endmodule : t2cr_edge

/* File: core/t2cr_top.sv */
// Reloadable 16-bit timer two with event counting and gating
// Behaviour
// RULE_01: Timer steps each machine cycle, every second one with prescale.
// RULE_02: Input select: stop, timer, pin event counter, pin gated timer.
// RULE_03: Gated timer counts only while the count pin is high.
// RULE_04: Event counter samples the pin at S5P2, counts high-then-low.
// RULE_05: Event increment becomes visible at S1P1 of the next cycle.
// RULE_06: External count levels must last at least one machine cycle.
// RULE_07: Software keeps prescale clear while counting pin events.
// RULE_08: Rollover from all ones sets the overflow flag, bit 6.
// RULE_09: Reload mode: upper bit 0 off, 10 on overflow, 11 on trigger.
// RULE_10: Overflow reload loads the preset value in the overflow cycle.
// RULE_11: Trigger reload copies the full 16-bit preset into the counter.
// RULE_12: Trigger pin sampled at S5P2; reload happens at next S2P1.
// RULE_13: Trigger edge sets external reload flag only when enabled.
// RULE_14: With reload off, enabled trigger edges still set the flag.
// RULE_15: Channel-0 polarity bit picks rising or falling edge for its flag.
// RULE_16: Control register is bit addressable over its eight bit addresses.
// RULE_17: Software writes ones to the pin latches before use.
// RULE_18: All updates step on the machine-cycle phase; reset clears them. Bus and bit writes take effect on any clock.
`timescale 1ns/1ps
module t2cr_top
    import t2cr_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input wire logic [7:0] sfr_addr,
    input wire logic [7:0] sfr_wdata,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] bit_addr,
    input wire logic bit_wdata,
    input wire logic bit_wr,
    output logic [7:0] sfr_rdata,
    input wire logic count_gate_pin,
    input wire logic reload_trigger_pin,
    input wire logic ch0_pin,
    output logic overflow_irq,
    output logic external_reload_irq,
    output logic ch0_irq
);
    typedef struct packed {
        logic [3:0] phase;
        logic tog;
        logic [7:0] ctrl;
        logic [15:0] count;
        logic [15:0] reload;
        logic overflow_flag;
        logic external_reload_flag;
        logic ch0_request_flag;
        logic external_reload_enable;
        logic [7:0] rdata;
    } t2cr_core_s;

    t2cr_core_s st_r;
    t2cr_core_s st_nxt;

    logic [T2CR_NUM_PINS-1:0] pins;
    logic [1:0] sel;
    logic [1:0] rmode;
    logic ps;
    logic pre_ok;
    logic cyc_start;
    logic tick;
    logic ovf_evt;
    logic trig_evt;
    logic ch0_evt;
    logic wr_cnt;

    t2cr_pin_if pin_if[T2CR_NUM_PINS] ();

    assign pins = {ch0_pin, reload_trigger_pin, count_gate_pin};

    // One synchroniser and sampler per input pin
    generate
        for (genvar i = 0; i < T2CR_NUM_PINS; i++) begin : g_pin
            assign pin_if[i].sample_en = (st_r.phase == T2CR_PH_S5P2);
            t2cr_edge u_edge (
                .clock(clock),
                .rst(rst),
                .pin(pins[i]),
                .pif(pin_if[i])
            );
        end
    endgenerate

    assign sel = st_r.ctrl[T2CR_CTRL_SEL +: 2];
    assign rmode = st_r.ctrl[T2CR_CTRL_RLD +: 2];
    assign ps = st_r.ctrl[T2CR_CTRL_PS];
    assign cyc_start = (st_r.phase == T2CR_PH_S1P1); // RULE_18
    assign pre_ok = !ps || st_r.tog; // RULE_01
    assign tick = cyc_start && (
        (sel == T2CR_SEL_TIMER && pre_ok) || // RULE_01 RULE_02
        (sel == T2CR_SEL_GATED && pre_ok &&
         pin_if[T2CR_PIN_CNT].level) || // RULE_03
        (sel == T2CR_SEL_EVENT && pin_if[T2CR_PIN_CNT].fall)); // RULE_05
    assign ovf_evt = tick && (st_r.count == T2CR_CNT_MAX); // RULE_08
    assign trig_evt = (st_r.phase == T2CR_PH_S2P1) &&
                      pin_if[T2CR_PIN_TRIG].fall; // RULE_12
    assign ch0_evt = cyc_start && (st_r.ctrl[T2CR_CTRL_CH0_POL] ?
                     pin_if[T2CR_PIN_CH0].rise :
                     pin_if[T2CR_PIN_CH0].fall); // RULE_15
    assign wr_cnt = sfr_wr && (sfr_addr == T2CR_ADDR_CNT_LO ||
                               sfr_addr == T2CR_ADDR_CNT_HI);

    always_comb begin
        st_nxt = st_r;
        if (st_r.phase == T2CR_PH_LAST) begin
            st_nxt.phase = T2CR_PH_S1P1; // RULE_18
        end else begin
            st_nxt.phase = st_r.phase + 4'h1;
        end
        // Divide-by-two prescaler steps once per machine cycle
        if (cyc_start && ps) begin
            st_nxt.tog = !st_r.tog; // RULE_01
        end
        if (tick) begin
            if (ovf_evt && rmode == T2CR_RLD_OVF) begin
                st_nxt.count = st_r.reload; // RULE_10 RULE_09
            end else begin
                st_nxt.count = st_r.count + 16'h0001;
            end
        end
        if (trig_evt && rmode == T2CR_RLD_TRIG) begin
            st_nxt.count = st_r.reload; // RULE_11 RULE_09
        end
        // Byte writes; software write to the counter wins over counting
        if (sfr_wr) begin
            if (sfr_addr == T2CR_ADDR_CTRL) begin
                st_nxt.ctrl = sfr_wdata;
            end else if (sfr_addr == T2CR_ADDR_RLD_LO) begin
                st_nxt.reload[7:0] = sfr_wdata;
            end else if (sfr_addr == T2CR_ADDR_RLD_HI) begin
                st_nxt.reload[15:8] = sfr_wdata;
            end else if (sfr_addr == T2CR_ADDR_CNT_LO) begin
                st_nxt.count[7:0] = sfr_wdata;
            end else if (sfr_addr == T2CR_ADDR_CNT_HI) begin
                st_nxt.count[15:8] = sfr_wdata;
            end else if (sfr_addr == T2CR_ADDR_IRQ) begin
                st_nxt.overflow_flag = sfr_wdata[T2CR_IRQ_OVF];
                st_nxt.external_reload_flag = sfr_wdata[T2CR_IRQ_EXF];
                st_nxt.ch0_request_flag = sfr_wdata[T2CR_IRQ_CH0];
            end else if (sfr_addr == T2CR_ADDR_EN) begin
                st_nxt.external_reload_enable = sfr_wdata[T2CR_EN_EXEN];
            end
        end
        if (bit_wr && bit_addr[7:3] == T2CR_ADDR_CTRL[7:3]) begin
            st_nxt.ctrl[bit_addr[2:0]] = bit_wdata; // RULE_16
        end
        // Hardware set wins over a software clear
        if (ovf_evt) begin
            st_nxt.overflow_flag = 1'b1; // RULE_08
        end
        if (trig_evt && st_r.external_reload_enable) begin
            st_nxt.external_reload_flag = 1'b1; // RULE_13 RULE_14
        end
        if (ch0_evt) begin
            st_nxt.ch0_request_flag = 1'b1; // RULE_15
        end
        if (sfr_rd) begin
            if (sfr_addr == T2CR_ADDR_CTRL) begin
                st_nxt.rdata = st_r.ctrl;
            end else if (sfr_addr == T2CR_ADDR_RLD_LO) begin
                st_nxt.rdata = st_r.reload[7:0];
            end else if (sfr_addr == T2CR_ADDR_RLD_HI) begin
                st_nxt.rdata = st_r.reload[15:8];
            end else if (sfr_addr == T2CR_ADDR_CNT_LO) begin
                st_nxt.rdata = st_r.count[7:0];
            end else if (sfr_addr == T2CR_ADDR_CNT_HI) begin
                st_nxt.rdata = st_r.count[15:8];
            end else if (sfr_addr == T2CR_ADDR_IRQ) begin
                st_nxt.rdata = 8'h00;
                st_nxt.rdata[T2CR_IRQ_OVF] = st_r.overflow_flag;
                st_nxt.rdata[T2CR_IRQ_EXF] = st_r.external_reload_flag;
                st_nxt.rdata[T2CR_IRQ_CH0] = st_r.ch0_request_flag;
            end else if (sfr_addr == T2CR_ADDR_EN) begin
                st_nxt.rdata = 8'h00;
                st_nxt.rdata[T2CR_EN_EXEN] = st_r.external_reload_enable;
            end else begin
                st_nxt.rdata = 8'h00;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            st_r <= '{phase: T2CR_PH_S1P1, tog: 1'b0, ctrl: T2CR_CTRL_RST,
                      count: T2CR_CNT_RST, reload: T2CR_RLD_RST,
                      overflow_flag: 1'b0, external_reload_flag: 1'b0,
                      ch0_request_flag: 1'b0, external_reload_enable: 1'b0,
                      rdata: 8'h00}; // RULE_18
        end else begin
            st_r <= st_nxt;
        end
    end

    assign sfr_rdata = st_r.rdata;
    assign overflow_irq = st_r.overflow_flag;
    assign external_reload_irq = st_r.external_reload_flag;
    assign ch0_irq = st_r.ch0_request_flag;

    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    phase_wrap_a: assert property ( // RULE_18
        st_r.phase == T2CR_PH_LAST |=> st_r.phase == T2CR_PH_S1P1 ##11
        st_r.phase == T2CR_PH_LAST)
        else $error("machine cycle is not twelve clocks");
    stop_hold_a: assert property ( // RULE_02
        sel == T2CR_SEL_STOP && !wr_cnt && !trig_evt |=> $stable(st_r.count))
        else $error("stopped counter moved");
    timer_step_a: assert property ( // RULE_01
        cyc_start && sel == T2CR_SEL_TIMER && !ps && !wr_cnt &&
        st_r.count != T2CR_CNT_MAX |=>
        st_r.count == $past(st_r.count) + 16'h0001)
        else $error("timer did not step in a machine cycle");
    prescale_skip_a: assert property ( // RULE_01
        cyc_start && sel == T2CR_SEL_TIMER && ps && !st_r.tog &&
        !wr_cnt && !trig_evt |=> $stable(st_r.count))
        else $error("prescaled timer stepped every cycle");
    gate_halt_a: assert property ( // RULE_03
        cyc_start && sel == T2CR_SEL_GATED && !pin_if[T2CR_PIN_CNT].level &&
        !wr_cnt && !trig_evt |=> $stable(st_r.count))
        else $error("gated timer counted with gate low");
    event_step_a: assert property ( // RULE_05
        cyc_start && sel == T2CR_SEL_EVENT && pin_if[T2CR_PIN_CNT].fall &&
        !wr_cnt && st_r.count != T2CR_CNT_MAX |=>
        st_r.count == $past(st_r.count) + 16'h0001)
        else $error("event edge not counted at cycle start");
    ovf_flag_a: assert property ( // RULE_08
        ovf_evt |=> overflow_irq)
        else $error("rollover did not set overflow flag");
    ovf_reload_a: assert property ( // RULE_10
        ovf_evt && rmode == T2CR_RLD_OVF && !wr_cnt |=>
        st_r.count == $past(st_r.reload))
        else $error("overflow reload missing");
    trig_reload_a: assert property ( // RULE_11
        trig_evt && rmode == T2CR_RLD_TRIG && !wr_cnt |=>
        st_r.count == $past(st_r.reload))
        else $error("trigger reload missing");
    exf_set_a: assert property ( // RULE_13
        trig_evt && st_r.external_reload_enable |=> external_reload_irq)
        else $error("enabled trigger edge did not set flag");
    ctrl_bit_a: assert property ( // RULE_16
        bit_wr && bit_addr[7:3] == T2CR_ADDR_CTRL[7:3] |=>
        st_r.ctrl[$past(bit_addr[2:0])] == $past(bit_wdata))
        else $error("control bit write lost");

    overflow_reload_c: cover property (ovf_evt && rmode == T2CR_RLD_OVF);
    trigger_reload_c: cover property (trig_evt && rmode == T2CR_RLD_TRIG);
    event_count_c: cover property (tick && sel == T2CR_SEL_EVENT);
    ch0_rise_c: cover property (ch0_evt && st_r.ctrl[T2CR_CTRL_CH0_POL]);
endmodule : t2cr_top

/* File: verification/t2cr_pin_model.sv */
// Model of the external count, trigger and channel-0 pin drivers
`timescale 1ns/1ps
module t2cr_pin_model
    import t2cr_pkg::*;
(
    input wire logic clock,
    output logic count_gate_pin,
    output logic reload_trigger_pin,
    output logic ch0_pin
);
    // Port latches hold ones, so idle pins sit high
    initial begin
        count_gate_pin = 1'b1;
        reload_trigger_pin = 1'b1;
        ch0_pin = 1'b1;
    end

    // Set one pin, then hold it for whole machine cycles
    task automatic drive(input int which, input logic v, input int mc);
        int n;
        n = (mc < 1) ? 1 : mc;
        @(negedge clock);
        case (which)
            T2CR_PIN_CNT: count_gate_pin = v;
            T2CR_PIN_TRIG: reload_trigger_pin = v;
            default: ch0_pin = v;
        endcase
        repeat (n * T2CR_OSC_PER_CYCLE) @(negedge clock);
    endtask : drive
endmodule : t2cr_pin_model

/* File: verification/t2cr_top_tb.sv */
// Self-checking bench for the reloadable timer two block
`timescale 1ns/1ps
module t2cr_top_tb;
    import t2cr_pkg::*;
    `define CHK(n, e, s) begin num_checks++; if ((s) !== (e)) begin \
        failures++; $display("BAD %s exp %h got %h", n, e, s); end end
    logic clock, rst, sfr_wr, sfr_rd, bit_wdata, bit_wr;
    logic [7:0] sfr_addr, sfr_wdata, bit_addr, sfr_rdata;
    logic count_gate_pin, reload_trigger_pin, ch0_pin;
    logic overflow_irq, external_reload_irq, ch0_irq;
    logic [2:0] irqs;
    int failures = 0;
    int num_checks = 0;
    int cycles = 0;
    assign irqs = {ch0_irq, external_reload_irq, overflow_irq};

    t2cr_top dut (.clock(clock), .rst(rst), .sfr_addr(sfr_addr),
        .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
        .bit_addr(bit_addr), .bit_wdata(bit_wdata), .bit_wr(bit_wr),
        .sfr_rdata(sfr_rdata), .count_gate_pin(count_gate_pin),
        .reload_trigger_pin(reload_trigger_pin), .ch0_pin(ch0_pin),
        .overflow_irq(overflow_irq),
        .external_reload_irq(external_reload_irq), .ch0_irq(ch0_irq));
    t2cr_pin_model pins (.clock(clock), .count_gate_pin(count_gate_pin),
        .reload_trigger_pin(reload_trigger_pin), .ch0_pin(ch0_pin));

    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    task automatic stop_test();
        $display("Checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : stop_test

    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            failures++;
            stop_test();
        end
    end

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clock);
        sfr_addr = a;
        sfr_wdata = d;
        sfr_wr = 1'b1;
        @(negedge clock);
        sfr_wr = 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clock);
        sfr_addr = a;
        sfr_rd = 1'b1;
        @(negedge clock);
        sfr_rd = 1'b0;
        d = sfr_rdata;
    endtask : rd

    task automatic bw(input logic [7:0] a, input logic v);
        @(negedge clock);
        bit_addr = a;
        bit_wdata = v;
        bit_wr = 1'b1;
        @(negedge clock);
        bit_wr = 1'b0;
    endtask : bw

    task automatic rd16(output logic [15:0] d);
        rd(T2CR_ADDR_CNT_HI, d[15:8]);
        rd(T2CR_ADDR_CNT_LO, d[7:0]);
    endtask : rd16

    // Low byte advance over a span; two reads add two clocks
    task automatic rate(input int clks, input logic [7:0] e, input string n);
        logic [7:0] a;
        logic [7:0] b;
        rd(T2CR_ADDR_CNT_LO, a);
        repeat (clks) @(negedge clock);
        rd(T2CR_ADDR_CNT_LO, b);
        `CHK(n, e, b - a)
    endtask : rate

    task automatic wait_irq(input int b, input int lim);
        int k;
        k = 0;
        while (irqs[b] !== 1'b1 && k < lim) begin
            @(negedge clock);
            k++;
        end
        `CHK("irq wait", 1'b1, irqs[b])
    endtask : wait_irq

    initial begin
        logic [7:0] v;
        logic [15:0] w;
        logic [7:0] om [4] = '{8'h00, 8'h08, 8'h10, 8'h18};
        logic [7:0] tc [4] = '{8'h18, 8'h18, 8'h00, 8'h08};
        logic [7:0] te [4] = '{8'h08, 8'h00, 8'h08, 8'h08};
        logic tf [4] = '{1'b1, 1'b0, 1'b1, 1'b1};
        logic [15:0] tw [4] = '{16'h1234, 16'h1234, 16'h0005, 16'h0005};
        logic [15:0] oc [4] = '{16'h0000, 16'h0000, 16'h1234, 16'h0000};
        {sfr_wr, sfr_rd, bit_wr, bit_wdata} = 4'h0;
        {sfr_addr, sfr_wdata, bit_addr} = 24'h000000;
        rst = 1'b1;
        repeat (8) @(negedge clock);
        rst = 1'b0;
        for (int a = 8'hc1; a <= 8'hc8; a++) begin
            rd(8'(a), v);
            `CHK("reset value", 8'h00, v)
        end
        rate(118, 8'h00, "stopped");
        wr(T2CR_ADDR_CTRL, 8'h01);
        rate(118, 8'h0a, "timer");
        bw(8'hcf, 1'b1);
        rd(T2CR_ADDR_CTRL, v);
        `CHK("bit write", 8'h81, v)
        rate(238, 8'h0a, "prescaled");
        bw(8'hcf, 1'b0);
        wr(T2CR_ADDR_CTRL, 8'h03);
        pins.drive(T2CR_PIN_CNT, 1'b0, 1);
        rate(118, 8'h00, "gate low");
        pins.drive(T2CR_PIN_CNT, 1'b1, 1);
        rate(118, 8'h0a, "gate high");
        wr(T2CR_ADDR_CTRL, 8'h02);
        wr(T2CR_ADDR_CNT_LO, 8'h00);
        wr(T2CR_ADDR_CNT_HI, 8'h00);
        repeat (3) begin
            pins.drive(T2CR_PIN_CNT, 1'b0, 2);
            pins.drive(T2CR_PIN_CNT, 1'b1, 2);
        end
        rd16(w);
        `CHK("events", 16'h0003, w)
        wr(T2CR_ADDR_RLD_LO, 8'h34);
        wr(T2CR_ADDR_RLD_HI, 8'h12);
        for (int i = 0; i < 4; i++) begin
            wr(T2CR_ADDR_CTRL, om[i]);
            wr(T2CR_ADDR_CNT_LO, 8'hfd);
            wr(T2CR_ADDR_CNT_HI, 8'hff);
            wr(T2CR_ADDR_IRQ, 8'h00);
            wr(T2CR_ADDR_CTRL, om[i] | 8'h01);
            wait_irq(0, 60);
            rd16(w);
            `CHK("ovf count", oc[i], w)
            rd(T2CR_ADDR_IRQ, v);
            `CHK("ovf flag", 8'h40, v)
        end
        for (int i = 0; i < 4; i++) begin
            wr(T2CR_ADDR_CTRL, tc[i]);
            wr(T2CR_ADDR_EN, te[i]);
            wr(T2CR_ADDR_CNT_LO, 8'h05);
            wr(T2CR_ADDR_CNT_HI, 8'h00);
            wr(T2CR_ADDR_IRQ, 8'h00);
            pins.drive(T2CR_PIN_TRIG, 1'b0, 2);
            pins.drive(T2CR_PIN_TRIG, 1'b1, 1);
            `CHK("ext flag", tf[i], external_reload_irq)
            rd16(w);
            `CHK("trig count", tw[i], w)
        end
        wr(T2CR_ADDR_CTRL, 8'h40);
        wr(T2CR_ADDR_IRQ, 8'h00);
        pins.drive(T2CR_PIN_CH0, 1'b0, 2);
        `CHK("ch0 fall", 1'b0, ch0_irq)
        pins.drive(T2CR_PIN_CH0, 1'b1, 2);
        `CHK("ch0 rise", 1'b1, ch0_irq)
        wr(T2CR_ADDR_CTRL, 8'h00);
        wr(T2CR_ADDR_IRQ, 8'h00);
        pins.drive(T2CR_PIN_CH0, 1'b0, 2);
        `CHK("ch0 fall", 1'b1, ch0_irq)
        pins.drive(T2CR_PIN_CH0, 1'b1, 1);
        stop_test();
    end
endmodule : t2cr_top_tb
